// ==== logic/isf_interrupt_status_flags.sv ====
// Interrupt status flags with enable, write-one clear and wake code clear
`default_nettype none
module isf_interrupt_status_flags
	import isf_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Host register port
	input wire isf_req_s HOST_REQ,
	output logic [15:0] HOST_RDATA,
	// Event sources and unit enables
	input wire isf_ev_s EVENTS,
	input wire logic [11:0] TS_UNIT_EN,
	input wire logic [11:0] TRIG_UNIT_EN,
	// Interrupt output
	output logic IRQ
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Byte enables to a bit mask of the written lanes
	function automatic logic [15:0] lane_mask(input logic [1:0] be);
		logic [15:0] m;
		m = 16'h0000;
		if (be[0]) begin
			m = m | ISF_LANE0_MASK;
		end
		if (be[1]) begin
			m = m | ISF_LANE1_MASK;
		end
		return m;
	endfunction : lane_mask

	// Merge written data into a register within a mask
	function automatic logic [15:0] merge_wr(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] m);
		return (old & ~m) | (wd & m);
	endfunction : merge_wr

	////////////////////////////////////////////////////////////////////////////////
	// State and working signals

	isf_state_s st_r; // Registered state
	isf_state_s st_nxt; // Next state
	logic [15:0] src; // Event levels by status position
	logic [15:0] set_v; // Flags set this cycle
	logic [15:0] clr_v; // Flags cleared this cycle
	logic [15:0] lanes; // Written byte lanes
	logic [15:0] ier_view; // Enable register as software and the gate see it
	logic wr_isr; // Write to status register
	logic wr_ier; // Write to enable register
	logic wr_pmc; // Write to power control register

	// Address decode
	assign wr_isr = HOST_REQ.wr && (HOST_REQ.addr == ISF_ISR_OFS);
	assign wr_ier = HOST_REQ.wr && (HOST_REQ.addr == ISF_IER_OFS);
	assign wr_pmc = HOST_REQ.wr && (HOST_REQ.addr == ISF_PMC_OFS);
	assign lanes = lane_mask(HOST_REQ.be);

	// Enable bits 12 and 10 are live ORs of the unit enables, never stored
	always_comb begin
		ier_view = st_r.interrupt_enable_reg;
		ier_view[ISF_B_TS] = |TS_UNIT_EN;
		ier_view[ISF_B_TRIG] = |TRIG_UNIT_EN;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		st_nxt = st_r;
		// Gather event levels at their status positions
		src = 16'h0000;
		src[ISF_B_LINK] = EVENTS.link_up;
		src[ISF_B_TXDONE] = EVENTS.tx_done;
		src[ISF_B_RXFRAME] = EVENTS.rx_frame;
		src[ISF_B_TS] = (|EVENTS.ts_ready) | EVENTS.egress_ts;
		src[ISF_B_RXOVR] = EVENTS.rx_overrun;
		src[ISF_B_TRIG] = (|EVENTS.trig_done) | (|EVENTS.trig_err);
		src[ISF_B_TXSTOP] = EVENTS.tx_stop;
		src[ISF_B_RXSTOP] = EVENTS.rx_stop;
		src[ISF_B_TXSPACE] = EVENTS.tx_space;
		src[ISF_B_WFRAME] = EVENTS.wake_frame;
		src[ISF_B_SIGPKT] = EVENTS.sig_packet;
		src[ISF_B_LUWAKE] = EVENTS.linkup_wake;
		src[ISF_B_EDWAKE] = EVENTS.energy_wake;
		// Rising edges set flags, so a held level cannot re-set after a clear
		set_v = src & ~st_r.src_prev;
		// Link flag follows both edges of the link level
		set_v[ISF_B_LINK] = src[ISF_B_LINK] ^ st_r.src_prev[ISF_B_LINK];
		st_nxt.src_prev = src;
		// Write-one clear touches only the upper flags and bit 6
		clr_v = 16'h0000;
		if (wr_isr) begin
			clr_v = HOST_REQ.wdata & lanes & ISF_W1C_MASK;
		end
		// Wake flags clear only by an exact code in the power control field
		if (wr_pmc && HOST_REQ.be[0]) begin
			case (HOST_REQ.wdata[ISF_PMC_HI:ISF_PMC_LO])
				ISF_CLR_WFRAME: begin
					clr_v[ISF_B_WFRAME] = 1'b1;
				end
				ISF_CLR_SIGPKT: begin
					clr_v[ISF_B_SIGPKT] = 1'b1;
				end
				ISF_CLR_LUWAKE: begin
					clr_v[ISF_B_LUWAKE] = 1'b1;
				end
				ISF_CLR_EDWAKE: begin
					clr_v[ISF_B_EDWAKE] = 1'b1;
				end
				default: begin
					clr_v = clr_v;
				end
			endcase
		end
		// Set applied after clear so a same-cycle event survives; reserved bits masked
		st_nxt.interrupt_status = ((st_r.interrupt_status & ~clr_v) | set_v) & (ISF_W1C_MASK | ISF_WAKE_MASK);
		// Enable and power control registers
		if (wr_ier) begin
			st_nxt.interrupt_enable_reg = merge_wr(st_r.interrupt_enable_reg, HOST_REQ.wdata, lanes & ISF_IER_RW_MASK);
		end
		if (wr_pmc) begin
			st_nxt.pmc = merge_wr(st_r.pmc, HOST_REQ.wdata, lanes);
		end
		// Read data captured on the read strobe; reading has no side effect
		if (HOST_REQ.rd) begin
			case (HOST_REQ.addr)
				ISF_IER_OFS: begin
					st_nxt.rdata = ier_view;
				end
				ISF_ISR_OFS: begin
					st_nxt.rdata = st_r.interrupt_status;
				end
				ISF_PMC_OFS: begin
					st_nxt.rdata = st_r.pmc;
				end
				default: begin
					st_nxt.rdata = 16'h0000;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	// All flags and stored enable bits start cleared; enable bits 12 and 10 follow the unit enables
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			st_r.interrupt_enable_reg <= ISF_IER_RST;
			st_r.interrupt_status <= ISF_ISR_RST;
			st_r.pmc <= ISF_PMC_RST;
			st_r.src_prev <= 16'h0000;
			st_r.rdata <= 16'h0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign HOST_RDATA = st_r.rdata;
	// Combinational so an enable write takes effect on the pin at once
	assign IRQ = |(st_r.interrupt_status & ier_view);

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	// A write-one to bit 9 with no new stop event
	sequence s_clear_txstop;
		wr_isr && HOST_REQ.be[1] && HOST_REQ.wdata[ISF_B_TXSTOP] && !set_v[ISF_B_TXSTOP];
	endsequence

	// A wake frame code write with no new wake frame
	sequence s_code_wframe;
		wr_pmc && HOST_REQ.be[0] && (HOST_REQ.wdata[5:2] == 4'h8) && !set_v[ISF_B_WFRAME];
	endsequence

	// The other three wake codes, each with no new event on its own flag
	sequence s_code_sigpkt;
		wr_pmc && HOST_REQ.be[0] && (HOST_REQ.wdata[5:2] == 4'h4) && !set_v[ISF_B_SIGPKT];
	endsequence

	sequence s_code_luwake;
		wr_pmc && HOST_REQ.be[0] && (HOST_REQ.wdata[5:2] == 4'h2) && !set_v[ISF_B_LUWAKE];
	endsequence

	sequence s_code_edwake;
		wr_pmc && HOST_REQ.be[0] && (HOST_REQ.wdata[5:2] == 4'h1) && !set_v[ISF_B_EDWAKE];
	endsequence

	// A cleared stop flag whose level still stands one cycle later
	sequence s_txstop_held;
		s_clear_txstop ##1 $stable(EVENTS.tx_stop);
	endsequence

	// Interrupt pin
	chk_irq_enabled_flag: assert property (st_r.interrupt_status[ISF_B_RXFRAME] && st_r.interrupt_enable_reg[ISF_B_RXFRAME] |-> IRQ)
		else $error("irq low with enabled flag set");
	// Enable bit 12 is never stored, so the unit enables alone must open the gate
	chk_irq_unit_enable: assert property (st_r.interrupt_status[ISF_B_TS] && (|TS_UNIT_EN) |-> IRQ)
		else $error("irq low with timestamp flag and unit enable");
	chk_irq_off_no_flag: assert property (st_r.interrupt_status == 16'h0000 |-> !IRQ)
		else $error("irq high with no flag set");

	// Reads and write-one clears
	// A read alone may only add flags that a new event sets
	chk_read_keeps_flags: assert property (HOST_REQ.rd && !HOST_REQ.wr
		|=> st_r.interrupt_status == ($past(st_r.interrupt_status) | $past(set_v)))
		else $error("read changed status flags");
	chk_w1c_clears: assert property (s_clear_txstop |=> !st_r.interrupt_status[9])
		else $error("write one did not clear bit 9");
	chk_txspace_w1c: assert property (wr_isr && HOST_REQ.be[0] && HOST_REQ.wdata[ISF_B_TXSPACE]
		&& !set_v[ISF_B_TXSPACE] |=> !st_r.interrupt_status[ISF_B_TXSPACE])
		else $error("write one did not clear bit 6");
	// Any flag set on the edge of a clear write must survive it
	chk_set_beats_clear: assert property (wr_isr && (set_v != 16'h0000)
		|=> (st_r.interrupt_status & $past(set_v)) == $past(set_v))
		else $error("clear won over a new event");

	// Event edges
	chk_link_both_edges: assert property ($changed(EVENTS.link_up) |=> st_r.interrupt_status[15])
		else $error("link change did not set bit 15");
	chk_txdone_sets: assert property ($rose(EVENTS.tx_done) |=> st_r.interrupt_status[ISF_B_TXDONE])
		else $error("transmit done did not set bit 14");
	chk_rxframe_sets: assert property ($rose(EVENTS.rx_frame) |=> st_r.interrupt_status[ISF_B_RXFRAME])
		else $error("received frame did not set bit 13");
	chk_ts_sets_bit: assert property ($rose(|EVENTS.ts_ready) |=> st_r.interrupt_status[12])
		else $error("timestamp ready did not set bit 12");
	chk_overrun_sets: assert property ($rose(EVENTS.rx_overrun) |=> st_r.interrupt_status[ISF_B_RXOVR])
		else $error("receive overrun did not set bit 11");
	// Done and error vectors share one flag, so either may raise it
	chk_trig_sets: assert property ($rose((|EVENTS.trig_done) | (|EVENTS.trig_err))
		|=> st_r.interrupt_status[ISF_B_TRIG])
		else $error("trigger unit did not set bit 10");
	chk_txstop_sets: assert property ($rose(EVENTS.tx_stop) |=> st_r.interrupt_status[ISF_B_TXSTOP])
		else $error("transmit stop did not set bit 9");
	chk_rxstop_sets: assert property ($rose(EVENTS.rx_stop) |=> st_r.interrupt_status[ISF_B_RXSTOP])
		else $error("receive stop did not set bit 8");
	chk_txspace_sets: assert property ($rose(EVENTS.tx_space) |=> st_r.interrupt_status[ISF_B_TXSPACE])
		else $error("transmit space did not set bit 6");
	chk_sticky_flag: assert property (st_r.interrupt_status[8] && !wr_isr |=> st_r.interrupt_status[8])
		else $error("bit 8 dropped without a clear");
	// A level that stays high must not set again the flag that was just cleared
	chk_held_no_reset: assert property (s_txstop_held |=> !st_r.interrupt_status[ISF_B_TXSTOP])
		else $error("held stop level set bit 9 again");

	// Wake flags
	chk_wake_code: assert property (s_code_wframe |=> !st_r.interrupt_status[5])
		else $error("code 1000 did not clear bit 5");
	// Wake flags are read-only on the status register itself
	chk_w1c_keeps_wake: assert property (wr_isr && st_r.interrupt_status[ISF_B_WFRAME] |=> st_r.interrupt_status[ISF_B_WFRAME])
		else $error("status write cleared wake frame flag");
	chk_wake_ignores_w1c: assert property (st_r.interrupt_status[4] && !wr_pmc |=> st_r.interrupt_status[4])
		else $error("signature flag cleared without code");
	chk_sigpkt_code: assert property (s_code_sigpkt |=> !st_r.interrupt_status[ISF_B_SIGPKT])
		else $error("code 0100 did not clear bit 4");
	chk_luwake_code: assert property (s_code_luwake |=> !st_r.interrupt_status[ISF_B_LUWAKE])
		else $error("code 0010 did not clear bit 3");
	chk_edwake_code: assert property (s_code_edwake |=> !st_r.interrupt_status[ISF_B_EDWAKE])
		else $error("code 0001 did not clear bit 2");
	chk_energy_sets: assert property ($rose(EVENTS.energy_wake) |=> st_r.interrupt_status[ISF_B_EDWAKE])
		else $error("energy wake did not set bit 2");

	// Reserved bits and the enable view
	chk_reserved_zero: assert property ((st_r.interrupt_status & 16'h0083) == 16'h0000)
		else $error("reserved status bit set");
	// Reserved positions must also read back as zero on the port
	chk_reserved_rdata: assert property (HOST_REQ.rd && HOST_REQ.addr == ISF_ISR_OFS
		|=> (HOST_RDATA & 16'h0083) == 16'h0000)
		else $error("reserved status bit read as one");
	chk_ier_or_read: assert property (HOST_REQ.rd && HOST_REQ.addr == ISF_IER_OFS
		|=> HOST_RDATA[10] == $past(|TRIG_UNIT_EN))
		else $error("enable bit 10 not the trigger enable OR");
	chk_ier_ts_read: assert property (HOST_REQ.rd && HOST_REQ.addr == ISF_IER_OFS
		|=> HOST_RDATA[12] == $past(|TS_UNIT_EN))
		else $error("enable bit 12 not the timestamp enable OR");

endmodule : isf_interrupt_status_flags
`default_nettype wire

// ==== logic/isf_pkg.sv ====
// Package: offsets, masks, reset values and carriers for the interrupt status flag block
`default_nettype none
package isf_pkg;

	// Register offsets on the host register port
	localparam logic [11:0] ISF_IER_OFS = 12'h190; // Interrupt enable register
	localparam logic [11:0] ISF_ISR_OFS = 12'h192; // Interrupt status register
	localparam logic [11:0] ISF_PMC_OFS = 12'h184; // Power management control register

	// Reset values
	localparam logic [15:0] ISF_IER_RST = 16'h0000;
	localparam logic [15:0] ISF_ISR_RST = 16'h0000;
	localparam logic [15:0] ISF_PMC_RST = 16'h0000;

	// Status bit positions
	localparam int ISF_B_LINK = 15;
	localparam int ISF_B_TXDONE = 14;
	localparam int ISF_B_RXFRAME = 13;
	localparam int ISF_B_TS = 12;
	localparam int ISF_B_RXOVR = 11;
	localparam int ISF_B_TRIG = 10;
	localparam int ISF_B_TXSTOP = 9;
	localparam int ISF_B_RXSTOP = 8;
	localparam int ISF_B_TXSPACE = 6;
	localparam int ISF_B_WFRAME = 5;
	localparam int ISF_B_SIGPKT = 4;
	localparam int ISF_B_LUWAKE = 3;
	localparam int ISF_B_EDWAKE = 2;

	// Field masks
	localparam logic [15:0] ISF_W1C_MASK = 16'hFF40; // Bits cleared by writing one
	localparam logic [15:0] ISF_WAKE_MASK = 16'h003C; // Bits cleared through the power control field
	localparam logic [15:0] ISF_IER_RW_MASK = 16'hEBFC; // Writable enable bits
	localparam logic [15:0] ISF_LANE0_MASK = 16'h00FF;
	localparam logic [15:0] ISF_LANE1_MASK = 16'hFF00;

	// Power control clear field and its codes
	localparam int ISF_PMC_LO = 2;
	localparam int ISF_PMC_HI = 5;
	localparam logic [3:0] ISF_CLR_WFRAME = 4'h8;
	localparam logic [3:0] ISF_CLR_SIGPKT = 4'h4;
	localparam logic [3:0] ISF_CLR_LUWAKE = 4'h2;
	localparam logic [3:0] ISF_CLR_EDWAKE = 4'h1;

	// Host register request
	typedef struct packed {
		logic [11:0] addr;
		logic wr;
		logic rd;
		logic [1:0] be;
		logic [15:0] wdata;
	} isf_req_s;

	// Event sources, all levels
	typedef struct packed {
		logic link_up;
		logic tx_done;
		logic rx_frame;
		logic [11:0] ts_ready;
		logic egress_ts;
		logic rx_overrun;
		logic [11:0] trig_done;
		logic [11:0] trig_err;
		logic tx_stop;
		logic rx_stop;
		logic tx_space;
		logic wake_frame;
		logic sig_packet;
		logic linkup_wake;
		logic energy_wake;
	} isf_ev_s;

	// Whole state of the block
	typedef struct packed {
		logic [15:0] interrupt_enable_reg;
		logic [15:0] interrupt_status;
		logic [15:0] pmc;
		logic [15:0] src_prev;
		logic [15:0] rdata;
	} isf_state_s;

endpackage : isf_pkg
`default_nettype wire

// ==== verif/isf_host_model.sv ====
// Host CPU model that drives the register port of the status flag block
`default_nettype none
module isf_host_model
	import isf_pkg::*;
(
	// Clock
	input wire logic clk,
	// Register port
	output var isf_req_s req,
	input wire logic [15:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle port from time zero
	initial req = '0;

	////////////////////////////////////////////////////////////////////////////////
	// Write: called at a falling edge, held over the taking rising edge, then one idle cycle
	// The idle cycle keeps each access apart so no signal is assigned twice in one step
	task automatic wr(input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
		req = '{addr: a, wr: 1'b1, rd: 1'b0, be: be, wdata: d};
		@(negedge clk);
		req = '0;
		@(negedge clk);
	endtask : wr

	// Read: data is taken once the rising edge has answered
	task automatic rd(input logic [11:0] a, output logic [15:0] d);
		req = '{addr: a, wr: 1'b0, rd: 1'b1, be: 2'h3, wdata: 16'h0000};
		@(negedge clk);
		d = rdata;
		req = '0;
		@(negedge clk);
	endtask : rd
endmodule : isf_host_model
`default_nettype wire

// ==== verif/isf_interrupt_status_flags_tb.sv ====
// Self-checking bench for the interrupt status flag block
`default_nettype none
module isf_interrupt_status_flags_tb
	import isf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk, rst, irq; // Clock, reset, interrupt
	isf_req_s req; // Host request from the model
	logic [15:0] rdata, got; // Read data and last value read
	isf_ev_s ev; // Event sources
	logic [11:0] ts_en, trig_en; // Unit enables
	int n_fail, num_checks; // Counters
	// Status bit that each source in set_src sets
	localparam logic [15:0] BITS [15] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h1000, 16'h0800,
		16'h0400, 16'h0400, 16'h0200, 16'h0100, 16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0004};

	isf_interrupt_status_flags DUT (.CLK(clk), .RST(rst), .HOST_REQ(req), .HOST_RDATA(rdata), .EVENTS(ev),
		.TS_UNIT_EN(ts_en), .TRIG_UNIT_EN(trig_en), .IRQ(irq));
	isf_host_model host (.clk(clk), .req(req), .rdata(rdata));

	////////////////////////////////////////////////////////////////////////////////
	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Drive one source; the link line only toggles, since both of its edges count
	task automatic set_src(input int k, input logic v);
		case (k)
			0: if (v) ev.link_up = ~ev.link_up;
			1: ev.tx_done = v;
			2: ev.rx_frame = v;
			3: ev.ts_ready[11] = v;
			4: ev.egress_ts = v;
			5: ev.rx_overrun = v;
			6: ev.trig_done[0] = v;
			7: ev.trig_err[5] = v;
			8: ev.tx_stop = v;
			9: ev.rx_stop = v;
			10: ev.tx_space = v;
			11: ev.wake_frame = v;
			12: ev.sig_packet = v;
			13: ev.linkup_wake = v;
			default: ev.energy_wake = v;
		endcase
	endtask : set_src

	// Verdict and end of run
	task automatic close_out;
		if (n_fail == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence, all inputs changed at falling edges
	initial begin
		logic [3:0] code;
		n_fail = 0;
		num_checks = 0;
		ev = '0;
		ts_en = 12'h001;
		trig_en = 12'h000;
		rst = 1'b1;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		host.rd(ISF_ISR_OFS, got);
		check(got, 16'h0000);
		check({15'h0000, irq}, 16'h0000);
		// Enable read-only bits show the unit-enable ORs
		host.wr(ISF_IER_OFS, 2'h3, 16'hFFFF);
		host.rd(ISF_IER_OFS, got);
		check(got, 16'hFBFC);
		ts_en = 12'h010;
		trig_en = 12'h800;
		host.rd(ISF_IER_OFS, got);
		check(got, 16'hFFFC);
		host.rd(12'h194, got);
		check(got, 16'h0000);
		// Each source: set, sticky, gated, cleared
		for (int k = 0; k < 15; k++) begin
			set_src(k, 1'b1);
			repeat (2) @(negedge clk);
			set_src(k, 1'b0);
			host.rd(ISF_ISR_OFS, got);
			check(got, BITS[k]);
			check({15'h0000, irq}, 16'h0001);
			host.rd(ISF_ISR_OFS, got);
			check(got, BITS[k]);
			ts_en = 12'h000;
			trig_en = 12'h000;
			host.wr(ISF_IER_OFS, 2'h3, ~BITS[k]);
			check({15'h0000, irq}, 16'h0000);
			ts_en = 12'h010;
			trig_en = 12'h800;
			host.wr(ISF_IER_OFS, 2'h3, 16'hFFFF);
			if (k < 11) begin
				host.wr(ISF_ISR_OFS, 2'h3, BITS[k]);
			end else begin
				// Wake flags ignore the status write and need their own code
				host.wr(ISF_ISR_OFS, 2'h3, 16'hFFFF);
				host.rd(ISF_ISR_OFS, got);
				check(got, BITS[k]);
				code = 4'(4'h8 >> (k - 11));
				host.wr(ISF_PMC_OFS, 2'h1, {10'h000, code, 2'h0});
			end
			host.rd(ISF_ISR_OFS, got);
			check(got, 16'h0000);
			check({15'h0000, irq}, 16'h0000);
		end
		// New event on the same edge as its clear keeps the flag
		ev.tx_stop = 1'b1;
		host.wr(ISF_ISR_OFS, 2'h3, 16'h0200);
		host.rd(ISF_ISR_OFS, got);
		check(got, 16'h0200);
		ev.tx_stop = 1'b0;
		// Link going down is a change as well
		set_src(0, 1'b1);
		@(negedge clk);
		host.rd(ISF_ISR_OFS, got);
		check(got, 16'h8200);
		host.wr(ISF_ISR_OFS, 2'h3, 16'hFFFF);
		host.rd(ISF_ISR_OFS, got);
		check(got, 16'h0000);
		close_out();
	end
endmodule : isf_interrupt_status_flags_tb
`default_nettype wire
